// ===== core/stop_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module stop_ctrl #(
   parameter int RELEASE_CYCLES = stop_pkg::RELEASE_CYC,
   parameter int CW = 13
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic stop_exec,
   input wire logic irq_unmasked,
   input wire logic irq_ack_en,
   input wire logic periph_halted,
   input wire logic reset_req,
   output logic cpu_clk_en,
   output logic ram_en,
   output logic fast_osc_en,
   output logic slow_osc_en,
   output logic wdt_run_en,
   output logic comparator_en,
   output logic periph_halt_req,
   output logic port_hold,
   output logic cpu_vector_take,
   output logic cpu_resume,
   output logic cpu_reset_start
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   generate
      if (RELEASE_CYCLES < 1 || RELEASE_CYCLES >= (1 << CW)) begin : g_bad
         $error("release count does not fit the wake counter");
      end
   endgenerate

   // ---------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ---------------------------------------------------------------
   logic wr_pend_q, wr_pend_d;
   logic [7:0] wr_addr_q, wr_addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] opt_q, opt_d;
   logic [31:0] speed_q, speed_d;
   logic [31:0] cmp_q, cmp_d;
   logic [31:0] status;
   logic vec_last_q, vec_last_d;
   logic addr_ok;
   logic wdstby, wden, slowsel, cmpfilt;

   assign addr_ok = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign wdstby = opt_q[stop_pkg::WDSTBY_BIT];
   assign wden = opt_q[stop_pkg::WDEN_BIT];
   assign slowsel = speed_q[stop_pkg::SLOWSEL_BIT];
   assign cmpfilt = cmp_q[stop_pkg::CMPFILT_BIT];

   // address phase latches writes and fetches read data a cycle early
   always_comb begin
      wr_pend_d = addr_ok && hwrite;
      wr_addr_d = addr_ok ? haddr[7:0] : wr_addr_q;
      rdata_d = 32'h0000_0000;   // unmapped words read zero, OKAY
      if (addr_ok && !hwrite) begin
         unique case (haddr[7:0])
            stop_pkg::OPT_OFS: rdata_d = opt_q;
            stop_pkg::SPEED_OFS: rdata_d = speed_q;
            stop_pkg::CMP_OFS: rdata_d = cmp_q;
            stop_pkg::STAT_OFS: rdata_d = status;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      opt_d = opt_q;
      speed_d = speed_q;
      cmp_d = cmp_q;
      if (wr_pend_q) begin
         unique case (wr_addr_q)
            stop_pkg::OPT_OFS: opt_d = hwdata & 32'h0000_0011;
            stop_pkg::SPEED_OFS: speed_d = hwdata & 32'h0000_0010;
            stop_pkg::CMP_OFS: cmp_d = hwdata & 32'h0000_0001;
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
         opt_q <= stop_pkg::OPT_RST;
         speed_q <= stop_pkg::SPEED_RST;
         cmp_q <= stop_pkg::CMP_RST;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
         opt_q <= opt_d;
         speed_q <= speed_d;
         cmp_q <= cmp_d;
      end
   end

   // ---------------------------------------------------------------
   // standby sequencer
   // ---------------------------------------------------------------
   stop_pkg::stop_state_e st_q, st_d;
   logic ack_q, ack_d;
   logic tmr_load, tmr_en, tmr_expire;
   logic [CW-1:0] tmr_val;
   logic in_stop;

   // stop_exec is the only way out of RUN; entry waits on the peripherals
   always_comb begin
      st_d = st_q;
      ack_d = ack_q;
      vec_last_d = vec_last_q;
      tmr_load = 1'b0;
      tmr_val = CW'(RELEASE_CYCLES);
      cpu_vector_take = 1'b0;
      cpu_resume = 1'b0;
      cpu_reset_start = 1'b0;
      if (reset_req) begin
         st_d = stop_pkg::RUN;
         cpu_reset_start = 1'b1;
      end else begin
         unique case (st_q)
            stop_pkg::RUN: begin
               if (stop_exec) begin
                  st_d = stop_pkg::QUIESCE;
               end
            end
            stop_pkg::QUIESCE: begin
               if (periph_halted) begin
                  st_d = stop_pkg::STOPPED;
               end
            end
            stop_pkg::STOPPED: begin
               // a request already pending leaves at once
               if (irq_unmasked) begin
                  st_d = stop_pkg::OSC_WAIT;
                  ack_d = irq_ack_en;
                  tmr_load = 1'b1;
               end
            end
            stop_pkg::OSC_WAIT: begin
               if (tmr_expire) begin
                  st_d = stop_pkg::POST_WAIT;
                  tmr_load = 1'b1;
                  tmr_val = ack_q ? CW'(stop_pkg::WAIT_VEC_CLKS)
                                  : CW'(stop_pkg::WAIT_CONT_CLKS);
               end
            end
            stop_pkg::POST_WAIT: begin
               if (tmr_expire) begin
                  st_d = stop_pkg::RUN;
                  cpu_vector_take = ack_q;
                  cpu_resume = !ack_q;
                  vec_last_d = ack_q;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= stop_pkg::RUN;
         ack_q <= 1'b0;
         vec_last_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ack_q <= ack_d;
         vec_last_q <= vec_last_d;
      end
   end

   // release wait and wake wait share one counter; never both at once
   assign tmr_en = (st_q == stop_pkg::OSC_WAIT) ||
                   (st_q == stop_pkg::POST_WAIT);

   wake_timer #(.CW(CW)) u_wake_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(tmr_load),
      .load_val(tmr_val),
      .en(tmr_en),
      .expire(tmr_expire)
   );

   // ---------------------------------------------------------------
   // clock and peripheral gating
   // ---------------------------------------------------------------
   assign in_stop = (st_q != stop_pkg::RUN);

   // cpu and ram drop in quiesce so they are idle before stop is reached
   always_comb begin
      cpu_clk_en = (st_q == stop_pkg::RUN) ||
                   (st_q == stop_pkg::POST_WAIT);
      ram_en = cpu_clk_en;
      fast_osc_en = (st_q != stop_pkg::STOPPED);
      periph_halt_req = (st_q == stop_pkg::QUIESCE) ||
                        (st_q == stop_pkg::STOPPED);
      port_hold = in_stop;
      if (st_q == stop_pkg::STOPPED) begin
         slow_osc_en = slowsel || (wden && wdstby);
         wdt_run_en = wden && wdstby;
         comparator_en = !cmpfilt;
      end else begin
         slow_osc_en = 1'b1;
         wdt_run_en = wden;
         comparator_en = 1'b1;
      end
   end

   // status word shows live sequencer state; the halt request to the peripherals drops in hardware once STOPPED is left
   always_comb begin
      status = 32'h0000_0000;
      status[stop_pkg::ST_STOP_BIT] = in_stop;
      status[stop_pkg::ST_CPUCLK_BIT] = cpu_clk_en;
      status[stop_pkg::ST_FOSC_BIT] = fast_osc_en;
      status[stop_pkg::ST_SOSC_BIT] = slow_osc_en;
      status[stop_pkg::ST_WDT_BIT] = wdt_run_en;
      status[stop_pkg::ST_CMP_BIT] = comparator_en;
      status[stop_pkg::ST_VEC_BIT] = vec_last_q;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_stop_entry: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == stop_pkg::RUN && !stop_exec && !reset_req)
      |=> st_q == stop_pkg::RUN)
      else $error("left run without a stop strobe");

   a_pending_wake: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == stop_pkg::QUIESCE && periph_halted && !reset_req)
      ##1 (irq_unmasked && !reset_req) |=> st_q == stop_pkg::OSC_WAIT)
      else $error("pending request did not release at once");

   a_clocks_off: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q == stop_pkg::STOPPED |-> !cpu_clk_en && !fast_osc_en)
      else $error("cpu clock or fast osc on in stop");

   a_slow_osc: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q == stop_pkg::STOPPED |->
      slow_osc_en == (speed_q[stop_pkg::SLOWSEL_BIT] ||
      (opt_q[stop_pkg::WDEN_BIT] && opt_q[stop_pkg::WDSTBY_BIT])))
      else $error("slow osc gating wrong in stop");

   a_ram_first: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(periph_halt_req) |-> !ram_en && !cpu_clk_en)
      else $error("cpu or ram still running at entry");

   a_port_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == stop_pkg::STOPPED) |-> port_hold && $past(port_hold))
      else $error("port latch hold released in stop");

   a_periph_halt: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(st_q == stop_pkg::STOPPED) |-> $past(periph_halted))
      else $error("stop reached before peripherals halted");

   a_wdt_stby: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q == stop_pkg::STOPPED |->
      wdt_run_en == (opt_q[stop_pkg::WDEN_BIT] &&
      opt_q[stop_pkg::WDSTBY_BIT]))
      else $error("watchdog standby gating wrong");

   a_comp_run: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q == stop_pkg::STOPPED |->
      comparator_en != cmp_q[stop_pkg::CMPFILT_BIT])
      else $error("comparator gating wrong in stop");

   a_vec_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(cpu_clk_en) && st_q == stop_pkg::POST_WAIT && ack_q &&
      !reset_req) ##1 (!reset_req) [*8] ##1 (!reset_req) [*2]
      |-> cpu_vector_take)
      else $error("vector wait is not 11 clocks");

   a_cont_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(cpu_clk_en) && st_q == stop_pkg::POST_WAIT && !ack_q &&
      !reset_req) ##1 (!reset_req) [*2] |-> cpu_resume)
      else $error("resume wait is not 3 clocks");

   a_clk_held: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(st_q == stop_pkg::OSC_WAIT) |-> !cpu_clk_en [*8])
      else $error("cpu clock back before release time");

   a_reset_rel: assert property (@(posedge hclk) disable iff (!hresetn)
      reset_req |-> cpu_reset_start ##1 st_q == stop_pkg::RUN)
      else $error("reset did not release stop");

endmodule // stop_ctrl

`default_nettype wire

// ===== core/stop_pkg.sv
package stop_pkg;

   // ---------------------------------------------------------------
   // register map, byte addresses of 32-bit words
   // ---------------------------------------------------------------
   localparam logic [7:0] OPT_OFS = 8'h00;   // option byte mirror
   localparam logic [7:0] SPEED_OFS = 8'h04; // speed_mode_control_reg
   localparam logic [7:0] CMP_OFS = 8'h08;   // comparator setup
   localparam logic [7:0] STAT_OFS = 8'h0C;  // read-only status

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int WDSTBY_BIT = 0;      // watchdog_standby_run
   localparam int WDEN_BIT = 4;        // watchdog_enable_opt
   localparam int SLOWSEL_BIT = 4;     // interval_timer_slowclk_select
   localparam int CMPFILT_BIT = 0;     // comparator digital filter in use
   localparam logic [31:0] OPT_RST = 32'h0000_0000;
   localparam logic [31:0] SPEED_RST = 32'h0000_0000;
   localparam logic [31:0] CMP_RST = 32'h0000_0000;

   // status bits
   localparam int ST_STOP_BIT = 0;
   localparam int ST_CPUCLK_BIT = 1;
   localparam int ST_FOSC_BIT = 2;
   localparam int ST_SOSC_BIT = 3;
   localparam int ST_WDT_BIT = 4;
   localparam int ST_CMP_BIT = 5;
   localparam int ST_VEC_BIT = 8;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int RELEASE_TIME_NS = 27000;   // clock supply stop, typ
   localparam int RELEASE_CYC = RELEASE_TIME_NS * CLK_MHZ / 1000;
   localparam int WAIT_VEC_CLKS = 11;
   localparam int WAIT_CONT_CLKS = 3;

   // ---------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      RUN, QUIESCE, STOPPED, OSC_WAIT, POST_WAIT
   } stop_state_e;

endpackage

// ===== core/wake_timer.sv
`timescale 1ns/1ps
`default_nettype none

// down counter: loads a value, counts while enabled, flags last count
module wake_timer #(
   parameter int CW = 13
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic load,
   input wire logic [CW-1:0] load_val,
   input wire logic en,
   output logic expire
);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // the longer wake wait must fit the counter
   generate
      if (CW < 4) begin : g_bad_cw
         $error("wake counter too narrow for the wake waits");
      end
   endgenerate

   // ---------------------------------------------------------------
   // count
   // ---------------------------------------------------------------
   // load wins over counting so a new wait never inherits a stale tail
   always_comb begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = load_val;
      end else if (en && cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // expire must not look at load: the sequencer derives load from expire
   assign expire = en && (cnt_q == {{(CW-1){1'b0}}, 1'b1});

endmodule // wake_timer

`default_nettype wire

// ===== sim/cpu_irq_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// cpu core and interrupt controller facing the standby block
// ---------------------------------------------------------------
module cpu_irq_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic do_stop,
   input wire logic irq_pend,
   input wire logic ack_on,
   input wire logic [3:0] halt_lat,
   input wire logic periph_halt_req,
   output logic stop_exec,
   output logic irq_unmasked,
   output logic irq_ack_en,
   output logic periph_halted
);
   logic [3:0] cnt_q;

   // units confirm halt halt_lat+1 cycles after the request, so slow units are covered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_exec <= 1'b0;
         periph_halted <= 1'b0;
         cnt_q <= 4'h0;
      end else begin
         stop_exec <= do_stop;
         if (!periph_halt_req) begin
            periph_halted <= 1'b0;
            cnt_q <= 4'h0;
         end else if (cnt_q >= halt_lat) begin
            periph_halted <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   // request and acknowledge levels follow the bench
   assign irq_unmasked = irq_pend;
   assign irq_ack_en = ack_on;
endmodule // cpu_irq_model

`default_nettype wire

// ===== sim/tb_stop_mode_standby_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_stop_mode_standby_control;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int REL = 12;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, reset_req = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic do_stop = 1'b0, irq_pend = 1'b0, ack_on = 1'b0;
   logic [3:0] halt_lat = 4'h0;
   logic hreadyout, hresp, stop_exec, irq_unmasked, irq_ack_en;
   logic periph_halted, cpu_clk_en, ram_en, fast_osc_en, slow_osc_en;
   logic wdt_run_en, comparator_en, periph_halt_req, port_hold;
   logic cpu_vector_take, cpu_resume, cpu_reset_start, last_vec = 1'b0;
   logic [31:0] hrdata;
   logic [31:0] seed = 32'h1C;
   int fails = 0;
   int checks_done = 0;

   always #2.5 hclk = ~hclk;

   stop_ctrl #(.RELEASE_CYCLES(REL), .CW(13)) i_dut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .stop_exec(stop_exec), .irq_unmasked(irq_unmasked),
      .irq_ack_en(irq_ack_en), .periph_halted(periph_halted),
      .reset_req(reset_req), .cpu_clk_en(cpu_clk_en), .ram_en(ram_en),
      .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
      .wdt_run_en(wdt_run_en), .comparator_en(comparator_en),
      .periph_halt_req(periph_halt_req), .port_hold(port_hold),
      .cpu_vector_take(cpu_vector_take), .cpu_resume(cpu_resume),
      .cpu_reset_start(cpu_reset_start));

   cpu_irq_model i_cpu (.hclk(hclk), .hresetn(hresetn), .do_stop(do_stop),
      .irq_pend(irq_pend), .ack_on(ack_on), .halt_lat(halt_lat),
      .periph_halt_req(periph_halt_req), .stop_exec(stop_exec),
      .irq_unmasked(irq_unmasked), .irq_ack_en(irq_ack_en),
      .periph_halted(periph_halted));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // o holds filter, slow select, watchdog enable, watchdog standby
   function automatic logic [31:0] stat_exp(input logic stp,
      input logic [3:0] o);
      return {23'h0, last_vec, 2'h0, stp ? !o[3] : 1'b1,
         stp ? (o[1] & o[0]) : o[1], stp ? (o[2] | (o[1] & o[0])) : 1'b1,
         !stp, !stp, stp};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask

   // one single transfer; waits on hready, never on a cycle count
   task automatic ahb(input logic wr_en, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr_en;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] nul;
      ahb(1'b1, a, d, nul);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      chk(what, exp, d);
   endtask

   // stop strobe, then follow quiesce until the fast osc is cut
   task automatic enter(input logic [3:0] lat);
      int w;
      w = 0;
      @(posedge hclk);
      do_stop <= 1'b1;
      halt_lat <= lat;
      @(posedge hclk);
      do_stop <= 1'b0;
      #1;
      while (fast_osc_en !== 1'b0 && w < 64) begin
         if (periph_halt_req === 1'b1 && periph_halted !== 1'b1) begin
            chk("osc before halt", 1, fast_osc_en);
            chk("cpu off in quiesce", 0, cpu_clk_en);
         end
         @(posedge hclk);
         #1;
         w++;
      end
      chk("stop cpu clock", 0, cpu_clk_en);
      chk("stop ram", 0, ram_en);
      chk("stop port hold", 1, port_hold);
   endtask

   // raise the interrupt, measure clock-off time and the post wait
   task automatic wake(input logic ack);
      int n_off;
      int n_on;
      n_off = 0;
      n_on = 1;
      if (irq_pend !== 1'b1) begin
         @(posedge hclk);
         irq_pend <= 1'b1;
         #1;
      end
      while (fast_osc_en !== 1'b1 && n_on < 64) begin
         @(posedge hclk);
         #1;
         n_on++;
      end
      n_on = 1;
      while (cpu_clk_en === 1'b0 && n_off < 64) begin
         n_off++;
         @(posedge hclk);
         #1;
      end
      while (cpu_vector_take !== 1'b1 && cpu_resume !== 1'b1
         && n_on < 64) begin
         n_on++;
         @(posedge hclk);
         #1;
      end
      chk("release cycles", REL, n_off);
      chk("post wait", ack ? 11 : 3, n_on);
      chk("vector", ack, cpu_vector_take);
      chk("resume", !ack, cpu_resume);
      last_vec = ack;
      @(posedge hclk);
      irq_pend <= 1'b0;
      #1;
      chk("run port hold", 0, port_hold);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [3:0] o;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1;
      chk("reset cpu clock", 1, cpu_clk_en);
      chk("reset okay", 0, hresp);
      rd_chk("opt rst", stop_pkg::OPT_OFS, stop_pkg::OPT_RST);
      rd_chk("speed rst", stop_pkg::SPEED_OFS, stop_pkg::SPEED_RST);
      rd_chk("cmp rst", stop_pkg::CMP_OFS, stop_pkg::CMP_RST);
      wr(8'h10, 32'hFFFF_FFFF);
      wr(stop_pkg::STAT_OFS, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h10, 32'h0);
      rd_chk("status ro", stop_pkg::STAT_OFS, stat_exp(1'b0, 4'h0));
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         r = rnd();
         o = r[3:0];
         wr(stop_pkg::OPT_OFS, {27'h0, o[1], 3'h0, o[0]});
         wr(stop_pkg::SPEED_OFS, {27'h0, o[2], 4'h0});
         wr(stop_pkg::CMP_OFS, {31'h0, o[3]});
         chk("no stop w/o strobe", 1, cpu_clk_en);
         ack_on <= r[4];
         irq_pend <= (i == 3);
         enter((i == 0) ? 4'h7 : (r[7:4] & 4'h3));
         chk("slow osc", o[2] | (o[1] & o[0]), slow_osc_en);
         chk("watchdog", o[1] & o[0], wdt_run_en);
         chk("comparator", !o[3], comparator_en);
         if (i != 3) begin
            rd_chk("stat stop", stop_pkg::STAT_OFS, stat_exp(1'b1, o));
         end
         wake(r[4]);
         rd_chk("stat run", stop_pkg::STAT_OFS, stat_exp(1'b0, o));
      end
      $display("test stop and wake done");
      enter(4'h1);
      @(posedge hclk);
      reset_req <= 1'b1;
      #1;
      chk("reset start", 1, cpu_reset_start);
      @(posedge hclk);
      #1;
      chk("reset cpu clock", 1, cpu_clk_en);
      chk("reset fast osc", 1, fast_osc_en);
      @(posedge hclk);
      reset_req <= 1'b0;
      rd_chk("opt kept", stop_pkg::OPT_OFS, {27'h0, o[1], 3'h0, o[0]});
      $display("test reset release done");
      // a bus reset in the middle of stop must also release it
      enter(4'h0);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1;
      chk("hreset cpu clock", 1, cpu_clk_en);
      chk("hreset port hold", 0, port_hold);
      chk("hreset fast osc", 1, fast_osc_en);
      rd_chk("hreset opt", stop_pkg::OPT_OFS, stop_pkg::OPT_RST);
      $display("test bus reset done");
      end_of_test();
   end

   // cuts a hang short; the tests need well under a thousand cycles
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      end_of_test();
   end
endmodule // tb_stop_mode_standby_control

`default_nettype wire
